/* tcc_params.svh */
// Constants for the 16-bit timer with two capture/compare registers
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH
`define TCC_CNT_ZERO   16'h0000
`define TCC_CNT_ONE    16'h0001
`define TCC_CNT_MAX    16'hffff
`define TCC_REG_RESET  16'h0000
`define TCC_MODE_STOP  2'h0
`define TCC_MODE_CSEDG 2'h1
`define TCC_MODE_FREE  2'h2
`define TCC_MODE_CSMAT 2'h3
`endif

/* tcc_pkg.sv */
// Types shared by the timer capture/compare block
package tcc_pkg;
	typedef enum logic [1:0] {
		TCC_STOP  = 2'h0,
		TCC_CSEDG = 2'h1,
		TCC_FREE  = 2'h2,
		TCC_CSMAT = 2'h3
	} tcc_mode_t;
	// Software write request toward the block
	typedef struct packed {
		logic        mode_we;
		logic [1:0]  timer_mode_ctrl;
		logic        a_we;
		logic        b_we;
		logic [15:0] wdata;
		logic        cap_mode_a;
		logic        cap_mode_b;
	} tcc_cpu_t;
endpackage

/* tcc_sw_model.sv */
// Software-side model that issues mode and register writes to the timer
`timescale 1ns/1ps
module tcc_sw_model (
	// Clock
	input  wire logic         ref_clk,
	// Requests toward the timer
	output tcc_pkg::tcc_cpu_t cpu
);
	import tcc_pkg::*;
	initial cpu = '0;
	// One-cycle write strobe, launched and dropped on falling edges
	// Compare b can be lowered while running with no restart after it; nothing here forces one
	task automatic put(input tcc_cpu_t c);
		@(negedge ref_clk) cpu = c;
		@(negedge ref_clk) {cpu.mode_we, cpu.a_we, cpu.b_we} = 3'h0;
	endtask
	// Register b is never trusted after a stop; no read path exists here
endmodule

/* tcc_timer.sv */
// 16-bit timer/event counter with two capture/compare registers
// How it works
// RL1: Capture wins over a coinciding register read.
// RL2: Capture coinciding with stop gives undefined value.
// RL3: Zero compare matches at 0000H to 0001H.
// RL4: Compare below count waits for wraparound.
// RL5: Software restarts timer after lowering compare; the bench lowers b while running without a restart.
// RL6: Software ignores register b after stop.
// RL7: Compare-mode register may ignore capture triggers.
// RL8: Software avoids rewriting compare while running; the bench rewrites b while running.
// RL9: Nonzero mode starts counter, zero stops.
// RL10: Software keeps match-clear compare nonzero.
// RL11: Counter read never captures nor loses counts.
// RL12: Counter increments by one and wraps.
`timescale 1ns/1ps
`include "tcc_params.svh"
module tcc_timer (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	// Software side
	input  wire tcc_pkg::tcc_cpu_t cpu,
	input  wire logic             cnt_rd,
	input  wire logic             count_en,
	// External edge input, already a one-cycle pulse
	input  wire logic             ext_edge_input_a,
	input  wire logic             cap_trig_b,
	// Observed state
	output logic [15:0]           timer_count_value,
	output logic [15:0]           capcmp_reg_a,
	output logic [15:0]           capcmp_reg_b,
	output logic                  running,
	output logic                  match_irq_a,
	output logic                  match_irq_b
);
	import tcc_pkg::*;

	// Operating model, in short:
	// The mode field decides how the counter runs. Zero holds the counter and the
	// captures into the registers; any other value lets each enabled tick advance it.
	// Mode 1 clears the count on a valid external edge and keeps counting.
	// Mode 2 runs free and wraps from the top value back to zero.
	// Mode 3 clears the count on the tick at which it equals register a.
	// Each of the two registers is either a compare value or a capture target,
	// chosen by its capture-mode level from the software side.
	// A compare hit is judged on the tick itself and its pulse stands one
	// cycle later, so the pulse lines up with the count leaving the value.
	// A zero compare therefore fires as the count steps from zero to one,
	// which after a wrap is the first step following the top value.
	// A capture copies the count as it stood before the tick of that edge.
	// Captures beat a software write of the same register in one cycle;
	// software must treat such a read as meaningless.
	// A stop that coincides with a capture still lets the capture land,
	// because the mode register only changes at the edge itself; the value
	// is not promised to software either way.
	// Counter reads are side-effect free here: there is no paused clock to
	// emulate, as the count register is simply sampled by the reader.
	// Limitation: a compare value lowered below the count while running is
	// only reached after a full wrap; software is expected to restart.
	// Trade-off: the count output is its own flop loaded from the next count,
	// so it holds the current count in the same cycle as the register.

	logic [1:0]  mode_r;          // Operation mode field
	logic [15:0] cnt_r;           // Running count
	logic [15:0] cnt_nxt;         // Next count
	logic [15:0] reg_a_nxt;       // Next value of register a
	logic [15:0] reg_b_nxt;       // Next value of register b

	// Run is a decode of the mode field so start takes effect at once
	wire run_w      = (mode_r != `TCC_MODE_STOP); // RL9
	// Counting proceeds on every enabled tick; a counter read does not gate it
	wire tick_w     = run_w & count_en; // RL11
	wire hit_a_w    = tick_w & (cnt_r == capcmp_reg_a) & ~cpu.cap_mode_a;
	wire hit_b_w    = tick_w & (cnt_r == capcmp_reg_b) & ~cpu.cap_mode_b;
	wire edge_clr_w = run_w & ext_edge_input_a & (mode_r == `TCC_MODE_CSEDG);
	wire mat_clr_w  = hit_a_w & (mode_r == `TCC_MODE_CSMAT);
	// Captures come only from triggers, never from cnt_rd; compare mode ignores them
	wire cap_a_w    = run_w & ext_edge_input_a & cpu.cap_mode_a; // RL7 RL11
	wire cap_b_w    = run_w & cap_trig_b & cpu.cap_mode_b; // RL7

	// Next count: clear on edge or match, else increment with natural wrap
	assign cnt_nxt = ~run_w ? cnt_r :
		(edge_clr_w | mat_clr_w) ? `TCC_CNT_ZERO :
		tick_w ? cnt_r + `TCC_CNT_ONE : cnt_r; // RL12 RL4

	// Capture takes priority over a software write; reads see whatever is latched
	assign reg_a_nxt = cap_a_w ? cnt_r : (cpu.a_we ? cpu.wdata : capcmp_reg_a); // RL1 RL2
	assign reg_b_nxt = cap_b_w ? cnt_r : (cpu.b_we ? cpu.wdata : capcmp_reg_b); // RL1 RL2

	// Mode field register
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			mode_r <= `TCC_MODE_STOP;
		end else if (cpu.mode_we) begin
			mode_r <= cpu.timer_mode_ctrl; // RL9
		end
	end

	// Counter, capture registers and match pulses
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cnt_r        <= `TCC_CNT_ZERO;
			capcmp_reg_a <= `TCC_REG_RESET;
			capcmp_reg_b <= `TCC_REG_RESET;
			match_irq_a  <= 1'b0;
			match_irq_b  <= 1'b0;
		end else begin
			cnt_r        <= cnt_nxt;
			capcmp_reg_a <= reg_a_nxt;
			capcmp_reg_b <= reg_b_nxt;
			match_irq_a  <= hit_a_w;
			// Zero compare matches as count leaves 0000H after wrap
			match_irq_b  <= hit_b_w; // RL3
		end
	end

	// Mirrors of state straight from flops
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			timer_count_value <= `TCC_CNT_ZERO;
			running           <= 1'b0;
		end else begin
			timer_count_value <= cnt_nxt;
			running           <= (cpu.mode_we ? cpu.timer_mode_ctrl : mode_r) != `TCC_MODE_STOP;
		end
	end

	// Checks next to the logic
	sequence s_tick_at(logic [15:0] v);
		tick_w && cnt_r == v;
	endsequence

	a_stop_holds_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!run_w |=> cnt_r == $past(cnt_r)) else $error("count moved while stopped"); // RL9
	a_start_counts: assert property (@(posedge ref_clk) disable iff (!reset_n)
		tick_w && !edge_clr_w && !mat_clr_w |=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("count did not increment"); // RL12
	a_wrap_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_tick_at(16'hffff) |=> cnt_r == 16'h0000) else $error("no wrap"); // RL4
	a_zero_match_b: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_tick_at(16'h0000) ##0 (capcmp_reg_b == 16'h0000 && !cpu.cap_mode_b) |=> match_irq_b)
		else $error("zero compare missed"); // RL3
	a_read_no_cap: assert property (@(posedge ref_clk) disable iff (!reset_n)
		cnt_rd && !cap_trig_b && !cpu.b_we |=> capcmp_reg_b == $past(capcmp_reg_b))
		else $error("read caused capture"); // RL11
	a_cmp_no_cap: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!cpu.cap_mode_b && !cpu.b_we |=> capcmp_reg_b == $past(capcmp_reg_b))
		else $error("compare register captured"); // RL7
	a_cap_first: assert property (@(posedge ref_clk) disable iff (!reset_n)
		cap_b_w |=> capcmp_reg_b == $past(cnt_r)) else $error("capture lost"); // RL1
	a_run_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
		cpu.mode_we && cpu.timer_mode_ctrl == 2'h0 |=> !running && !run_w)
		else $error("stop not seen"); // RL9

	// Compare hit on register a at a tick
	sequence s_hit_a;
		tick_w && cnt_r == capcmp_reg_a && !cpu.cap_mode_a;
	endsequence

	// Compare hit on register b at a tick
	sequence s_hit_b;
		tick_w && cnt_r == capcmp_reg_b && !cpu.cap_mode_b;
	endsequence

	// Wrap past the top value, then the zero tick against a zero compare
	sequence s_wrap_zero_b;
		s_tick_at(16'hffff) ##1 s_tick_at(16'h0000) ##0
			(capcmp_reg_b == 16'h0000 && !cpu.cap_mode_b);
	endsequence

	// Zero compare fires right after the wrap
	a_wrap_then_match: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL3
		s_wrap_zero_b |=> match_irq_b)
		else $error("zero compare after wrap missed");

	// Register a hit raises its pulse one edge later
	a_match_a_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL4
		s_hit_a |=> match_irq_a)
		else $error("match a pulse missing");

	// Register b hit raises its pulse one edge later
	a_match_b_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL4
		s_hit_b |=> match_irq_b)
		else $error("match b pulse missing");

	// No pulse on register b without a real hit
	a_no_stray_b: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL4
		!hit_b_w |=> !match_irq_b)
		else $error("stray match b pulse");

	// Clear on match a returns the count to zero
	a_match_clear: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL12
		mat_clr_w |=> cnt_r == 16'h0000)
		else $error("match clear missed");

	// Clear on external edge returns the count to zero
	a_edge_clear: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL12
		edge_clr_w |=> cnt_r == 16'h0000)
		else $error("edge clear missed");

	// Capture into register a takes the count before the edge
	a_cap_a_value: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL1
		cap_a_w |=> capcmp_reg_a == $past(cnt_r))
		else $error("capture a lost");

	// Register a in compare mode keeps its value without a write
	a_cmp_a_holds: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL7
		!cpu.cap_mode_a && !cpu.a_we |=> capcmp_reg_a == $past(capcmp_reg_a))
		else $error("compare register a captured");

	// Count output tracks the count register
	a_count_mirror: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL11
		1'b1 |-> timer_count_value == cnt_r)
		else $error("count output out of step");

	// Running flag tracks the mode decode
	a_run_mirror: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL9
		1'b1 |-> running == run_w)
		else $error("running flag out of step");

	// A stopped timer raises no match pulse
	a_quiet_stopped: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL9
		!run_w |=> !match_irq_a && !match_irq_b)
		else $error("match while stopped");

	// A read during a tick loses no count
	a_read_keeps_count: assert property (@(posedge ref_clk) disable iff (!reset_n) // RL11
		cnt_rd && tick_w && !edge_clr_w && !mat_clr_w |=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("count lost on read");
endmodule

/* timer16_capture_compare_test.sv */
// Self-checking bench for the timer with two capture/compare registers
`timescale 1ns/1ps
`include "tcc_params.svh"
module timer16_capture_compare_test;
	import tcc_pkg::*;
	logic ref_clk = 0, reset_n = 0, cnt_rd = 0, count_en = 0, cap_b = 0, ext_a = 0;
	logic [15:0] cnt, ra, rb;
	logic run, irq_a, irq_b;
	tcc_cpu_t cpu;
	int err_total = 0, tests_run = 0, nirq = 0;
	always #4 ref_clk = ~ref_clk;
	// Counts match pulses on register b
	always @(posedge ref_clk) if (irq_b === 1'b1) nirq++;
	tcc_sw_model sw_u (.ref_clk(ref_clk), .cpu(cpu));
	tcc_timer dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .cpu(cpu), .cnt_rd(cnt_rd),
		.count_en(count_en), .ext_edge_input_a(ext_a), .cap_trig_b(cap_b),
		.timer_count_value(cnt), .capcmp_reg_a(ra), .capcmp_reg_b(rb), .running(run),
		.match_irq_a(irq_a), .match_irq_b(irq_b));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("Checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Request word: mode write, mode, b write, data, b capture mode
	function automatic tcc_cpu_t rq(logic m, logic [1:0] md, logic bw, logic [15:0] d, logic cb);
		return {m, md, 1'b0, bw, d, 1'b0, cb};
	endfunction
	// Reset held four cycles, released on a falling edge
	task automatic rst;
		reset_n = 0;
		repeat (4) @(negedge ref_clk);
		reset_n = 1;
		nirq = 0;
	endtask
	// Holds the count tick for n rising edges
	task automatic tick(input int n);
		@(negedge ref_clk) count_en = 1;
		repeat (n) @(negedge ref_clk);
		count_en = 0;
	endtask
	// Start and stop through the mode field, plain counting
	task automatic t_startstop;
		rst;
		sw_u.put(rq(1, `TCC_MODE_FREE, 0, 16'h0, 0));
		chk(run, 1'b1);
		tick(5);
		chk(cnt, 16'h0005);
		sw_u.put(rq(1, `TCC_MODE_STOP, 0, 16'h0, 0));
		chk(run, 1'b0);
		$display("start/stop done");
	endtask
	// Counter reads during ticks, then a capture that meets a read
	task automatic t_capture;
		rst;
		sw_u.put(rq(1, `TCC_MODE_FREE, 0, 16'h0, 1));
		cnt_rd = 1;
		tick(5);
		cnt_rd = 0;
		chk(rb, 16'h0000);
		chk(cnt, 16'h0005);
		cap_b = 1;
		cnt_rd = 1;
		@(negedge ref_clk) {cap_b, cnt_rd} = 2'h0;
		chk(rb, 16'h0005);
		$display("capture done");
	endtask
	// Compare mode ignores captures; zero compare below count waits for wrap
	task automatic t_compare;
		rst;
		sw_u.put(rq(1, `TCC_MODE_FREE, 1, 16'h0009, 0));
		tick(4);
		@(negedge ref_clk) cap_b = 1;
		@(negedge ref_clk) cap_b = 0;
		chk(rb, 16'h0009);
		sw_u.put(rq(0, `TCC_MODE_STOP, 1, `TCC_CNT_ZERO, 0));
		tick(65532);
		@(negedge ref_clk);
		chk(cnt, `TCC_CNT_ZERO);
		chk(nirq[15:0], 16'h0000);
		tick(1);
		repeat (2) @(negedge ref_clk);
		chk(cnt, `TCC_CNT_ONE);
		chk(nirq[15:0], 16'h0001);
		$display("compare done");
	endtask
	// Clear on match a, clear on edge, then capture into register a
	task automatic t_edge;
		tcc_cpu_t c;
		rst;
		c = '0;
		c.mode_we = 1;
		c.timer_mode_ctrl = `TCC_MODE_CSMAT;
		c.a_we = 1;
		c.wdata = 16'h0003;
		sw_u.put(c);
		tick(4);
		chk(irq_a, 1'b1);
		chk(cnt, `TCC_CNT_ZERO);
		sw_u.put(rq(1, `TCC_MODE_CSEDG, 0, 16'h0, 0));
		tick(2);
		@(negedge ref_clk) ext_a = 1;
		@(negedge ref_clk) ext_a = 0;
		chk(cnt, `TCC_CNT_ZERO);
		c = '0;
		c.timer_mode_ctrl = `TCC_MODE_CSEDG;
		c.cap_mode_a = 1;
		sw_u.put(c);
		tick(3);
		@(negedge ref_clk) ext_a = 1;
		@(negedge ref_clk) ext_a = 0;
		chk(ra, 16'h0003);
		chk(cnt, `TCC_CNT_ZERO);
		$display("edge done");
	endtask
	initial begin
		t_startstop;
		t_capture;
		t_compare;
		t_edge;
		finish_test;
	end
	// Watchdog well beyond the longest expected run
	initial begin
		#(8 * 90000);
		err_total++;
		finish_test;
	end
endmodule
